//--- src/sfr_core.sv
// top: sct fill completion and error recovery control handling
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
module sfr_core #(
   parameter int UNIT_CYC = sfr_pkg::UNIT_CYCLES
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   // key sector command
   input wire logic key_valid_in,
   input wire logic [15:0] key_action_in,
   input wire logic [15:0] key_function_in,
   input wire logic [15:0] key_select_in,
   input wire logic [15:0] key_value_in,
   // fill data path and media engine
   input wire logic fill_data_done_in,
   input wire logic media_done_in,
   input wire logic media_error_in,
   output logic media_stop_out,
   // other host commands
   input wire logic host_cmd_in,
   input wire logic host_cmd_is_status_in,
   output logic host_cmd_go_out,
   // timed drive command
   input wire logic cmd_start_in,
   input wire logic cmd_exec_in,
   input wire logic cmd_done_in,
   input wire logic cmd_is_write_in,
   input wire logic cmd_queued_in,
   input wire logic cmd_streaming_in,
   input wire logic out_of_order_in,
   output logic cmd_timeout_out,
   // task file outputs
   output logic tf_valid_out,
   output sfr_pkg::sfr_state_t fill_state_out,
   output logic [7:0] tf_error_out,
   output logic [7:0] tf_count_out,
   output logic [7:0] tf_number_out,
   output logic [7:0] tf_status_out,
   // register port
   input wire logic [3:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [15:0] reg_rdata_out
);
   import sfr_pkg::*;
   initial begin
      if (UNIT_CYC < 1) $error("sfr_core: UNIT_CYC must be at least 1");
   end
   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   function automatic logic is_bg(input logic [15:0] fn);
      return fn == FN_BG_PATTERN || fn == FN_BG_SECTOR;
   endfunction : is_bg
   function automatic logic is_blk(input logic [15:0] fn);
      return fn == FN_BLK_PATTERN || fn == FN_BLK_SECTOR;
   endfunction : is_blk
   sfr_state_t state_q;
   logic [15:0] sct_err_q;
   logic [15:0] rd_limit_q;
   logic [15:0] wr_limit_q;
   logic timer_run_q;
   logic timer_wr_q;
   logic expired;
   logic tf_valid_q;
   logic [7:0] tf_error_q;
   logic [7:0] tf_count_q;
   logic [7:0] tf_number_q;
   logic [7:0] tf_status_q;
   logic timeout_q;
   logic [15:0] rdata_q;
   logic fill_key;
   logic rec_key;
   logic bg_intr;
   logic rec_ok;
   logic limit_ok;
   assign fill_key = key_valid_in && key_action_in == ACT_FILL &&
                     (is_bg(key_function_in) || is_blk(key_function_in));
   assign rec_key = key_valid_in && key_action_in == ACT_RECOVERY;
   assign bg_intr = state_q == SFR_BG && host_cmd_in && !host_cmd_is_status_in;
   assign limit_ok = key_value_in >= LIMIT_MIN;
   assign rec_ok = (key_select_in == SEL_READ || key_select_in == SEL_WRITE) &&
                   (key_function_in == FN_GET ||
                    (key_function_in == FN_SET && limit_ok));
   // ------------------------------------------------------------
   // fill state machine
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_q <= SFR_IDLE;
      end else begin
         case (state_q)
            SFR_IDLE: begin
               if (fill_key) begin
                  state_q <= is_bg(key_function_in) ? SFR_BG : SFR_BLK;
               end
            end
            SFR_BG: begin
               if (bg_intr || media_error_in || media_done_in) begin
                  state_q <= SFR_IDLE;
               end
            end
            SFR_BLK: begin
               if (media_error_in || media_done_in) begin
                  state_q <= SFR_IDLE;
               end
            end
            default: state_q <= SFR_IDLE;
         endcase
      end
   end
   // stop media at once on interruption; incoming command may proceed
   assign media_stop_out = bg_intr;
   assign host_cmd_go_out = host_cmd_in && !(state_q == SFR_BLK);
   // ------------------------------------------------------------
   // sct status error code
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sct_err_q <= ERR_NONE;
      end else if (state_q == SFR_IDLE && fill_key) begin
         sct_err_q <= ERR_RUNNING;
      end else if (state_q == SFR_BG) begin
         if (bg_intr) begin
            sct_err_q <= EXT_BG_ABORTED;
         end else if (media_error_in) begin
            sct_err_q <= EXT_BG_MEDIA;
         end else if (media_done_in) begin
            sct_err_q <= ERR_NONE;
         end
      end else if (state_q == SFR_BLK) begin
         if (media_error_in) begin
            sct_err_q <= EXT_BLK_MEDIA;
         end else if (media_done_in) begin
            sct_err_q <= ERR_NONE;
         end
      end
   end
   // ------------------------------------------------------------
   // recovery limits, volatile
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rd_limit_q <= LIMIT_RESET;
         wr_limit_q <= LIMIT_RESET;
      end else if (rec_key && rec_ok && key_function_in == FN_SET) begin
         if (key_select_in == SEL_READ) begin
            rd_limit_q <= key_value_in;
         end else begin
            wr_limit_q <= key_value_in;
         end
      end else if (reg_wr_in && reg_addr_in == REG_READ_LIMIT) begin
         rd_limit_q <= reg_wdata_in;
      end else if (reg_wr_in && reg_addr_in == REG_WRITE_LIMIT) begin
         wr_limit_q <= reg_wdata_in;
      end
   end
   // ------------------------------------------------------------
   // task file completion
   // ------------------------------------------------------------
   // background completes on data receipt, blocking only on media end
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tf_valid_q <= 1'b0;
         tf_error_q <= TF_ERR_NONE;
         tf_count_q <= 8'h00;
         tf_number_q <= 8'h00;
         tf_status_q <= TF_STAT_OK;
      end else begin
         tf_valid_q <= 1'b0;
         if (state_q == SFR_BG && fill_data_done_in) begin
            tf_valid_q <= 1'b1;
            tf_error_q <= TF_ERR_NONE;
            tf_status_q <= TF_STAT_OK;
         end else if (state_q == SFR_BLK && media_error_in) begin
            tf_valid_q <= 1'b1;
            tf_error_q <= TF_ERR_ABORT;
            tf_count_q <= EXT_BLK_MEDIA[7:0];
            tf_number_q <= EXT_BLK_MEDIA[15:8];
            tf_status_q <= TF_STAT_ERR;
         end else if (state_q == SFR_BLK && media_done_in) begin
            tf_valid_q <= 1'b1;
            tf_error_q <= TF_ERR_NONE;
            tf_status_q <= TF_STAT_OK;
         end else if (rec_key && !rec_ok) begin
            tf_valid_q <= 1'b1;
            tf_error_q <= TF_ERR_ABORT;
            tf_count_q <= EXT_BAD_PARAM[7:0];
            tf_number_q <= EXT_BAD_PARAM[15:8];
            tf_status_q <= TF_STAT_ERR;
         end else if (rec_key) begin
            tf_valid_q <= 1'b1;
            tf_error_q <= TF_ERR_NONE;
            tf_status_q <= TF_STAT_OK;
            if (key_function_in == FN_GET) begin
               tf_count_q <= key_select_in == SEL_READ ? rd_limit_q[7:0] :
                             wr_limit_q[7:0];
               tf_number_q <= key_select_in == SEL_READ ? rd_limit_q[15:8] :
                              wr_limit_q[15:8];
            end
         end
      end
   end
   assign tf_valid_out = tf_valid_q;
   assign tf_error_out = tf_error_q;
   assign tf_count_out = tf_count_q;
   assign tf_number_out = tf_number_q;
   assign tf_status_out = tf_status_q;
   assign fill_state_out = state_q;
   // ------------------------------------------------------------
   // recovery timing of drive commands
   // ------------------------------------------------------------
   logic timed;
   logic start_ev;
   assign timed = !cmd_streaming_in && !(cmd_queued_in && out_of_order_in);
   // non-queued start on arrival, queued in-order on execution start
   assign start_ev = timed && (cmd_queued_in ? cmd_exec_in : cmd_start_in);
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         timer_run_q <= 1'b0;
         timer_wr_q <= 1'b0;
      end else if (cmd_done_in) begin
         timer_run_q <= 1'b0;
      end else if (start_ev) begin
         timer_run_q <= 1'b1;
         timer_wr_q <= cmd_is_write_in;
      end
   end
   sfr_recovery_timer #(.CYCLES(UNIT_CYC)) u_timer (
      .clk_sys_in(clk_sys_in),
      .reset_n_in(reset_n_in),
      .start_in(start_ev),
      .run_in(timer_run_q),
      .limit_in(timer_wr_q ? wr_limit_q : rd_limit_q),
      .expired_out(expired)
   );
   // sticky timeout until next timed command start; set wins
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         timeout_q <= 1'b0;
      end else if (expired && timer_run_q) begin
         timeout_q <= 1'b1;
      end else if (start_ev) begin
         timeout_q <= 1'b0;
      end
   end
   assign cmd_timeout_out = timeout_q;
   // ------------------------------------------------------------
   // register read port
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rdata_q <= 16'h0000;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            REG_READ_LIMIT: rdata_q <= rd_limit_q;
            REG_WRITE_LIMIT: rdata_q <= wr_limit_q;
            REG_SCT_ERR: rdata_q <= sct_err_q;
            REG_FLAGS: rdata_q <= {14'h0, state_q};
            REG_TF: rdata_q <= {tf_status_q, tf_error_q};
            REG_TIMEOUT: rdata_q <= {15'h0, timeout_q};
            default: rdata_q <= 16'h0000;
         endcase
      end
   end
   assign reg_rdata_out = rdata_q;
   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   bg_err_running_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      state_q != SFR_IDLE |-> sct_err_q == ERR_RUNNING)
      else $error("error code not FFFFh while fill runs");
   bg_abort_code_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      bg_intr |=> sct_err_q == EXT_BG_ABORTED && state_q == SFR_IDLE)
      else $error("background abort code wrong");
   bg_complete_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      state_q == SFR_BG && fill_data_done_in |=> tf_valid_q && tf_status_q == TF_STAT_OK)
      else $error("background completion missing");
   blk_no_early_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      state_q == SFR_BLK && !media_done_in && !media_error_in && !rec_key |=> !tf_valid_q)
      else $error("blocking completion too early");
   blk_err_tf_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      state_q == SFR_BLK && media_error_in |=>
      tf_status_q == TF_STAT_ERR && {tf_number_q, tf_count_q} == EXT_BLK_MEDIA)
      else $error("blocking error task file wrong");
   short_limit_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      rec_key && key_function_in == FN_SET && !limit_ok |=>
      tf_status_q == TF_STAT_ERR && $stable(rd_limit_q) && $stable(wr_limit_q))
      else $error("short limit not aborted");
   get_limit_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      rec_key && rec_ok && key_function_in == FN_GET && key_select_in == SEL_READ |=>
      {tf_number_q, tf_count_q} == $past(rd_limit_q) && tf_error_q == TF_ERR_NONE)
      else $error("returned limit wrong");
   untimed_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      (cmd_streaming_in && cmd_start_in && !timer_run_q) |=> !timer_run_q)
      else $error("streaming command timed");
   fill_bg_c: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in) bg_intr);
   fill_blk_c: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      state_q == SFR_BLK && media_done_in);
   set_limit_c: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
      rec_key && rec_ok && key_function_in == FN_SET);
endmodule : sfr_core

//--- inc/sfr_pkg.sv
// package: codes, status values and timing constants for the sct fill and recovery timer
package sfr_pkg;
   // ------------------------------------------------------------
   // key sector codes
   // ------------------------------------------------------------
   localparam logic [15:0] ACT_FILL = 16'h0002;
   localparam logic [15:0] ACT_RECOVERY = 16'h0003;
   localparam logic [15:0] FN_BG_PATTERN = 16'h0001;
   localparam logic [15:0] FN_BG_SECTOR = 16'h0002;
   localparam logic [15:0] FN_BLK_PATTERN = 16'h0101;
   localparam logic [15:0] FN_BLK_SECTOR = 16'h0102;
   localparam logic [15:0] FN_SET = 16'h0001;
   localparam logic [15:0] FN_GET = 16'h0002;
   localparam logic [15:0] SEL_READ = 16'h0001;
   localparam logic [15:0] SEL_WRITE = 16'h0002;
   // ------------------------------------------------------------
   // status codes
   // ------------------------------------------------------------
   localparam logic [15:0] ERR_RUNNING = 16'hFFFF;
   localparam logic [15:0] ERR_NONE = 16'h0000;
   localparam logic [15:0] EXT_BG_ABORTED = 16'h0008;
   localparam logic [15:0] EXT_BG_MEDIA = 16'h0009;
   localparam logic [15:0] EXT_BLK_MEDIA = 16'h0017;
   localparam logic [15:0] EXT_BAD_PARAM = 16'h0001;
   localparam logic [7:0] TF_STAT_OK = 8'h50;
   localparam logic [7:0] TF_STAT_ERR = 8'h51;
   localparam logic [7:0] TF_ERR_NONE = 8'h00;
   localparam logic [7:0] TF_ERR_ABORT = 8'h04;
   // ------------------------------------------------------------
   // timing and reset values
   // ------------------------------------------------------------
   localparam logic [15:0] LIMIT_MIN = 16'h0041;
   localparam logic [15:0] LIMIT_RESET = 16'h0000;
   localparam int UNIT_MS = 100;
   localparam int CLK_MHZ = 200;
   localparam int UNIT_CYCLES = UNIT_MS * 1000 * CLK_MHZ;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [3:0] REG_READ_LIMIT = 4'h0;
   localparam logic [3:0] REG_WRITE_LIMIT = 4'h1;
   localparam logic [3:0] REG_SCT_ERR = 4'h2;
   localparam logic [3:0] REG_FLAGS = 4'h3;
   localparam logic [3:0] REG_TF = 4'h4;
   localparam logic [3:0] REG_TIMEOUT = 4'h5;
   typedef enum logic [1:0] {SFR_IDLE, SFR_BG, SFR_BLK} sfr_state_t;
endpackage : sfr_pkg

//--- src/sfr_unit_tick.sv
// unit tick: one pulse per recovery time unit
`timescale 1ns/1ps
module sfr_unit_tick #(
   parameter int CYCLES = sfr_pkg::UNIT_CYCLES
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   // control
   input wire logic run_in,
   output logic tick_out
);
   import sfr_pkg::*;
   logic [31:0] cnt_q;
   initial begin
      if (CYCLES < 1) $error("sfr_unit_tick: CYCLES must be at least 1");
   end
   // divider, restarts whenever the timer is idle
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cnt_q <= 32'h0;
      end else if (!run_in || cnt_q == 32'(CYCLES - 1)) begin
         cnt_q <= 32'h0;
      end else begin
         cnt_q <= cnt_q + 32'h1;
      end
   end
   assign tick_out = run_in && (cnt_q == 32'(CYCLES - 1));
endmodule : sfr_unit_tick

//--- src/sfr_recovery_timer.sv
// recovery timer: counts units against a limit for one command
`timescale 1ns/1ps
module sfr_recovery_timer #(
   parameter int CYCLES = sfr_pkg::UNIT_CYCLES
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   // control
   input wire logic start_in,
   input wire logic run_in,
   input wire logic [15:0] limit_in,
   output logic expired_out
);
   import sfr_pkg::*;
   logic tick;
   logic [15:0] units_q;
   logic fired_q;
   sfr_unit_tick #(.CYCLES(CYCLES)) u_tick (
      .clk_sys_in(clk_sys_in),
      .reset_n_in(reset_n_in),
      .run_in(run_in && !start_in),
      .tick_out(tick)
   );
   // unit counter, limit zero means no timeout
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         units_q <= 16'h0;
         fired_q <= 1'b0;
      end else if (start_in || !run_in) begin
         units_q <= 16'h0;
         fired_q <= 1'b0;
      end else if (tick && limit_in != 16'h0 && !fired_q) begin
         units_q <= units_q + 16'h1;
         fired_q <= (units_q + 16'h1) == limit_in;
      end
   end
   assign expired_out = fired_q;
endmodule : sfr_recovery_timer

//--- dv/sfr_media_model.sv
// media engine model: ends or fails a running fill after a chosen delay
`timescale 1ns/1ps
module sfr_media_model (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   // fill progress from the block
   input wire sfr_pkg::sfr_state_t fill_state_in,
   input wire logic media_stop_in,
   // behaviour chosen by the bench
   input wire logic [31:0] delay_in,
   input wire logic err_in,
   // completion back to the block
   output logic media_done_out,
   output logic media_error_out
);
   import sfr_pkg::*;
   int cnt_q;
   // count while a fill runs; a stop abandons the fill for good
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cnt_q <= 0;
      end else if (fill_state_in == SFR_IDLE || media_stop_in) begin
         cnt_q <= 0;
      end else if (cnt_q <= delay_in) begin
         cnt_q <= cnt_q + 1;
      end
   end
   // one pulse only: the count moves past the delay right after
   assign media_done_out = (cnt_q == delay_in) && !err_in;
   assign media_error_out = (cnt_q == delay_in) && err_in;
endmodule : sfr_media_model

//--- dv/sfr_core_test.sv
// self-checking bench for the fill and recovery timer block
`timescale 1ns/1ps
`define CHK(g, e) chk(32'(g), 32'(e))
module sfr_core_test;
   import sfr_pkg::*;
   logic clk_sys_in = 1'h0, reset_n_in = 1'h0, key_valid_in = 1'h0;
   logic [15:0] key_action_in = '0, key_function_in = '0, key_select_in = '0;
   logic [15:0] key_value_in = '0, reg_wdata_in = '0, reg_rdata_out, v, fn;
   logic fill_data_done_in = 1'h0, media_done_in, media_error_in, media_stop_out;
   logic host_cmd_in = 1'h0, host_cmd_is_status_in = 1'h0, host_cmd_go_out;
   logic cmd_start_in = 1'h0, cmd_exec_in = 1'h0, cmd_done_in = 1'h0;
   logic cmd_is_write_in = 1'h0, cmd_queued_in = 1'h0, cmd_streaming_in = 1'h0;
   logic out_of_order_in = 1'h0, cmd_timeout_out, tf_valid_out, stop_seen, m_err = 1'h0;
   logic blk, ok, go_seen, reg_wr_in = 1'h0, reg_rd_in = 1'h0;
   logic [7:0] tf_error_out, tf_count_out, tf_number_out, tf_status_out;
   logic [3:0] reg_addr_in = '0;
   logic [15:0] lim [2];
   sfr_state_t fill_state_out;
   int n_mismatch = 0, check_count = 0, cyc = 0, m_delay = 1000;
   logic [15:0] fcode [4] = '{FN_BG_PATTERN, FN_BG_SECTOR, FN_BLK_PATTERN, FN_BLK_SECTOR};

   // 4 cycles per unit keeps every timeout short
   sfr_core #(.UNIT_CYC(4)) u_dut (.*);
   sfr_media_model u_media (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
      .fill_state_in(fill_state_out), .media_stop_in(media_stop_out), .delay_in(m_delay),
      .err_in(m_err), .media_done_out(media_done_in), .media_error_out(media_error_in));

   always #2.5 clk_sys_in = ~clk_sys_in;
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : conclude
   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         conclude();
      end
   end
   task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys_in);
      {reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, d, 1'h1};
      @(posedge clk_sys_in);
      reg_wr_in <= 1'h0;
   endtask : reg_wr
   // read data are registered: they stand from the cycle after the strobe until the next read
   task automatic reg_chk(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk_sys_in);
      {reg_addr_in, reg_rd_in} <= {a, 1'h1};
      @(posedge clk_sys_in);
      reg_rd_in <= 1'h0;
      #1 `CHK(reg_rdata_out, e);
   endtask : reg_chk
   task automatic key(input logic [15:0] a, f, s, d);
      @(posedge clk_sys_in);
      {key_action_in, key_function_in, key_select_in, key_value_in} <= {a, f, s, d};
      key_valid_in <= 1'h1;
      @(posedge clk_sys_in);
      key_valid_in <= 1'h0;
      #1;
   endtask : key
   // w: 4 data done, 3 host command, 2 start, 1 exec, 0 done
   task automatic pulse(input int w);
      @(posedge clk_sys_in);
      {fill_data_done_in, host_cmd_in, cmd_start_in, cmd_exec_in, cmd_done_in} <= 5'h1 << w;
      // both are combinational on the pulse, so they are caught while it stands
      #1 {stop_seen, go_seen} = {media_stop_out, host_cmd_go_out};
      @(posedge clk_sys_in);
      {fill_data_done_in, host_cmd_in, cmd_start_in, cmd_exec_in, cmd_done_in} <= 5'h0;
      #1;
   endtask : pulse
   // bounded wait: w 0 for an answer, 1 for the fill to end
   task automatic wait_for(input int w);
      repeat (60) begin
         if (w == 0 ? tf_valid_out === 1'h1 : fill_state_out === SFR_IDLE) return;
         @(posedge clk_sys_in);
         #1;
      end
   endtask : wait_for
   function automatic logic [31:0] rec_exp(input logic good, input logic [15:0] d);
      if (good) return {TF_STAT_OK, TF_ERR_NONE, d[15:8], d[7:0]};
      return {TF_STAT_ERR, TF_ERR_ABORT, EXT_BAD_PARAM[15:8], EXT_BAD_PARAM[7:0]};
   endfunction : rec_exp
   function automatic logic [15:0] fill_exp(input logic b, input logic e);
      if (!e) return ERR_NONE;
      return b ? EXT_BLK_MEDIA : EXT_BG_MEDIA;
   endfunction : fill_exp
   // one timed command with limit 2 units: fires 8 cycles after the timer starts
   task automatic timed(input logic wr, q, st, oo, fire);
      {cmd_is_write_in, cmd_queued_in, cmd_streaming_in, out_of_order_in} <= {wr, q, st, oo};
      pulse(2);
      if (q) begin
         repeat (12) @(posedge clk_sys_in);
         #1 `CHK(cmd_timeout_out, 1'h0);
         pulse(1);
      end
      repeat (4) @(posedge clk_sys_in);
      #1 `CHK(cmd_timeout_out, 1'h0);
      repeat (8) @(posedge clk_sys_in);
      #1 `CHK(cmd_timeout_out, fire);
      pulse(0);
   endtask : timed
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      void'($urandom(32'hF722));
      repeat (6) @(posedge clk_sys_in);
      reset_n_in <= 1'h1;
      reg_chk(REG_READ_LIMIT, LIMIT_RESET);
      `CHK(tf_status_out, TF_STAT_OK);
      // set with random limits straddling the least value, then read back
      lim = '{16'h0000, 16'h0000};
      for (int i = 0; i < 14; i++) begin
         v = (i < 2) ? LIMIT_MIN - 16'(i) : 16'(40 + $urandom_range(0, 60));
         key(ACT_RECOVERY, FN_SET, i[0] ? SEL_WRITE : SEL_READ, v);
         ok = v >= LIMIT_MIN;
         if (ok) lim[i[0]] = v;
         if (ok) `CHK({tf_status_out, tf_error_out}, rec_exp(1'h1, v) >> 16);
         else `CHK({tf_status_out, tf_error_out, tf_number_out, tf_count_out}, rec_exp(ok, v));
         key(ACT_RECOVERY, FN_GET, i[1] ? SEL_WRITE : SEL_READ, 16'h0000);
         `CHK(tf_valid_out, 1'h1);
         `CHK({tf_status_out, tf_error_out, tf_number_out, tf_count_out},
              rec_exp(1'h1, lim[i[1]]));
      end
      reg_chk(REG_WRITE_LIMIT, lim[1]);
      key(ACT_RECOVERY, 16'h0005, SEL_READ, 16'h0064);
      `CHK({tf_status_out, tf_error_out, tf_number_out, tf_count_out}, rec_exp(0, 0));
      key(ACT_RECOVERY, FN_SET, 16'h0003, 16'h0064);
      `CHK({tf_status_out, tf_error_out, tf_number_out, tf_count_out}, rec_exp(0, 0));
      reg_chk(REG_TF, {TF_STAT_ERR, TF_ERR_ABORT});
      $display("recovery control test done");
      // background fill: answer on data, status command passes, other command stops it
      m_delay = 1000;
      key(ACT_FILL, FN_BG_PATTERN, 16'h0000, 16'h0000);
      `CHK(fill_state_out, SFR_BG);
      reg_chk(REG_FLAGS, 16'(SFR_BG));
      reg_chk(REG_SCT_ERR, ERR_RUNNING);
      pulse(4);
      `CHK({tf_valid_out, tf_status_out, fill_state_out}, {1'h1, TF_STAT_OK, SFR_BG});
      host_cmd_is_status_in <= 1'h1;
      pulse(3);
      `CHK({stop_seen, go_seen, fill_state_out}, {1'h0, 1'h1, SFR_BG});
      host_cmd_is_status_in <= 1'h0;
      pulse(3);
      `CHK({stop_seen, go_seen, fill_state_out}, {1'h1, 1'h1, SFR_IDLE});
      reg_chk(REG_SCT_ERR, EXT_BG_ABORTED);
      $display("background abort test done");
      // status commands during each fill: pass in background, held while blocking
      host_cmd_is_status_in <= 1'h1;
      // every fill code, ending well and on a media error
      for (int i = 0; i < 8; i++) begin
         fn = fcode[i % 4];
         blk = fn[8];
         m_err = i[2];
         m_delay = 6 + $urandom_range(0, 20);
         key(ACT_FILL, fn, 16'h0000, 16'h0000);
         pulse(3);
         `CHK({go_seen, stop_seen}, {!blk, 1'h0});
         pulse(4);
         `CHK(tf_valid_out, !blk);
         if (blk) wait_for(0);
         if (blk) `CHK({tf_valid_out, tf_status_out, tf_error_out},
                       {1'h1, m_err ? {TF_STAT_ERR, TF_ERR_ABORT} : {TF_STAT_OK, TF_ERR_NONE}});
         if (blk && m_err) `CHK({tf_number_out, tf_count_out}, EXT_BLK_MEDIA);
         wait_for(1);
         reg_chk(REG_SCT_ERR, fill_exp(blk, m_err));
      end
      host_cmd_is_status_in <= 1'h0;
      $display("fill completion test done");
      // recovery timers against timed commands
      reg_wr(REG_READ_LIMIT, 16'h0002);
      reg_wr(REG_WRITE_LIMIT, 16'h0002);
      // timeout is sticky until a timed start, so untimed cases follow one that never fires
      timed(1'h1, 1'h1, 1'h0, 1'h0, 1'h1);
      timed(1'h0, 1'h0, 1'h0, 1'h0, 1'h1);
      reg_chk(REG_TIMEOUT, 16'h0001);
      reg_wr(REG_WRITE_LIMIT, 16'h0000);
      timed(1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
      timed(1'h0, 1'h0, 1'h1, 1'h0, 1'h0);
      timed(1'h0, 1'h1, 1'h0, 1'h1, 1'h0);
      $display("timer test done");
      // limits are lost across a reset in mid-run
      @(posedge clk_sys_in);
      reset_n_in <= 1'h0;
      repeat (2) @(posedge clk_sys_in);
      reset_n_in <= 1'h1;
      reg_chk(REG_READ_LIMIT, LIMIT_RESET);
      $display("reset test done");
      conclude();
   end
endmodule : sfr_core_test
